/* File: lhc_loop_sysclk.sv */
// Loop control state machine, tuning word history and system clock control
// Assumes DPLL and tuning words on core_clk; reference status and sysclk
// multiplier edges arrive asynchronously from pins
//
// Decided for this implementation: register access over AXI4-Lite.
module lhc_loop_sysclk #(
	parameter int TW_W = 32
) (
	input  wire logic                  core_clk,
	input  wire logic                  sys_rst,
	input  wire lhc_pkg::lhc_axi_req_s axi_req,
	output wire lhc_pkg::lhc_axi_rsp_s axi_rsp,
	input  wire logic                  ref_present,
	input  wire logic [1:0]            ref_index,
	input  wire logic                  sysclk_ref_edge,
	input  wire logic                  sysclk_fb_edge,
	input  wire logic                  dpll_lock_in,
	input  wire logic [TW_W-1:0]       tw_in,
	input  wire logic                  tw_valid,
	input  wire logic [TW_W-1:0]       free_run_tuning_word,
	output wire logic [TW_W-1:0]       tune_word,
	output wire logic                  dpll_locked,
	output wire logic [1:0]            loop_state,
	output wire logic                  profile_load,
	output wire logic                  sysclk_locked,
	output wire logic                  sysclk_stable,
	output wire logic                  monitors_en,
	output wire logic                  crystal_route,
	output wire logic [1:0]            prescale_sel,
	output wire logic                  doubler_en,
	output wire logic [1:0]            post_div_sel,
	output wire logic [7:0]            fb_div,
	output wire logic [23:0]           nominal_period
);
	import lhc_pkg::*;

	localparam int ACC_W = TW_W + 15;

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		logic             aw_have;
		logic [13:0]      aw_idx;
		logic             w_have;
		logic [31:0]      wdata;
		logic [3:0]       wstrb;
		logic             bvalid;
		logic [1:0]       bresp;
		logic             rvalid;
		logic [31:0]      rdata;
		logic [1:0]       rresp;
		logic [7:0]       fdiv;
		logic [7:0]       cfg;
		logic [7:0]       mode;
		logic [23:0]      period;
		logic [23:0]      stab;
		logic [3:0]       avglen;
		logic [7:0]       act_fdiv;
		logic [7:0]       act_cfg;
		logic             ref_s1;
		logic             ref_s2;
		logic [1:0]       id_s1;
		logic [1:0]       id_s2;
		logic [1:0]       e_s1;
		logic [1:0]       e_s2;
		logic [1:0]       e_s3;
		logic             ld_run;
		logic [8:0]       ld_cnt;
		logic [8:0]       ld_idle;
		logic             syslock;
		logic [23:0]      stab_cnt;
		logic             stable;
		lhc_loop_e        lstate;
		logic [3:0]       sw_cnt;
		logic [1:0]       cur_ref;
		logic             lock;
		logic             profile_load;
		logic [ACC_W-1:0] acc;
		logic [15:0]      acc_n;
		logic [TW_W-1:0]  avg;
		logic             hist_ok;
		logic [TW_W-1:0]  tune;
	} lhc_state_s;

	lhc_state_s       st;
	lhc_state_s       nx;
	logic             upd;
	logic             ref_ok;
	logic             uhold;
	logic             ref_rise;
	logic             fb_rise;
	logic [ACC_W-1:0] acc_sum;
	logic [31:0]      wm;

	function automatic logic [31:0] wmerge(input logic [31:0] o, input logic [31:0] d,
		input logic [3:0] s);
		logic [31:0] r;
		r = o;
		for (int i = 0; i < 4; i++)
			if (s[i])
				r[8*i +: 8] = d[8*i +: 8];
		return r;
	endfunction

	// Returns {mapped, data}
	function automatic logic [32:0] reg_read(input lhc_state_s s, input logic [13:0] i);
		case (i)
			IDX_FDIV:   return {1'b1, 24'h0, s.fdiv};
			IDX_CFG:    return {1'b1, 24'h0, s.cfg};
			IDX_MODE:   return {1'b1, 24'h0, s.mode};
			IDX_PERIOD: return {1'b1, 8'h0, s.period};
			IDX_STAB:   return {1'b1, 8'h0, s.stab};
			IDX_AVGLEN: return {1'b1, 28'h0, s.avglen};
			IDX_UPDATE: return {1'b1, 32'h0};
			IDX_AVG:    return {1'b1, 32'(s.avg)};
			IDX_STATUS: return {1'b1, 24'h0, s.cur_ref, s.hist_ok, s.stable, s.syslock,
				s.lock, s.lstate};
			default:    return {1'b0, 32'h0};
		endcase
	endfunction

	always_comb
	begin
		nx = st;
		upd = 1'b0;
		acc_sum = '0;
		wm = '0;
		nx.profile_load = 1'b0;

		// ----------------------------------------
		// AXI4-Lite slave
		// ----------------------------------------
		if (axi_req.awvalid && axi_rsp.awready)
		begin
			nx.aw_have = 1'b1;
			nx.aw_idx = axi_req.awaddr[15:2];
		end
		if (axi_req.wvalid && axi_rsp.wready)
		begin
			nx.w_have = 1'b1;
			nx.wdata = axi_req.wdata;
			nx.wstrb = axi_req.wstrb;
		end
		if (st.bvalid && axi_req.bready)
			nx.bvalid = 1'b0;
		if (st.aw_have && st.w_have && !st.bvalid)
		begin
			nx.aw_have = 1'b0;
			nx.w_have = 1'b0;
			nx.bvalid = 1'b1;
			nx.bresp = reg_read(st, st.aw_idx)[32] ? RESP_OKAY : RESP_SLVERR;
			case (st.aw_idx)
				IDX_UPDATE:
					upd = st.wstrb[0] && st.wdata[7:0] == UPDATE_GO;
				IDX_FDIV:
				begin
					wm = wmerge({24'h0, st.fdiv}, st.wdata, st.wstrb);
					nx.fdiv = wm[7:0];
				end
				IDX_CFG:
				begin
					wm = wmerge({24'h0, st.cfg}, st.wdata, st.wstrb);
					nx.cfg = wm[7:0];
				end
				IDX_MODE:
				begin
					wm = wmerge({24'h0, st.mode}, st.wdata, st.wstrb);
					nx.mode = wm[7:0];
				end
				IDX_PERIOD:
				begin
					wm = wmerge({8'h0, st.period}, st.wdata, st.wstrb);
					nx.period = wm[23:0];
				end
				IDX_STAB:
				begin
					wm = wmerge({8'h0, st.stab}, st.wdata, st.wstrb);
					nx.stab = wm[23:0];
				end
				IDX_AVGLEN:
				begin
					wm = wmerge({28'h0, st.avglen}, st.wdata, st.wstrb);
					nx.avglen = wm[3:0];
				end
				default:
					wm = '0;
			endcase
		end
		if (axi_req.arvalid && axi_rsp.arready)
		begin
			nx.rvalid = 1'b1;
			{nx.rresp[1], nx.rdata} = reg_read(st, axi_req.araddr[15:2]);
			nx.rresp[1] = !nx.rresp[1];
			nx.rresp[0] = 1'b0;
		end
		else if (st.rvalid && axi_req.rready)
			nx.rvalid = 1'b0;

		// Active divider settings move only on update
		if (upd)
		begin
			nx.act_fdiv = (st.fdiv < FDIV_MIN) ? FDIV_MIN : st.fdiv;
			nx.act_cfg = st.cfg;
		end

		// ----------------------------------------
		// Pin synchronisers
		// ----------------------------------------
		nx.ref_s1 = ref_present;
		nx.ref_s2 = st.ref_s1;
		nx.id_s1 = ref_index;
		nx.id_s2 = st.id_s1;
		nx.e_s1 = {sysclk_fb_edge, sysclk_ref_edge};
		nx.e_s2 = st.e_s1;
		nx.e_s3 = st.e_s2;

		// ----------------------------------------
		// Multiplier lock detector
		// ----------------------------------------
		ref_rise = st.e_s2[0] && !st.e_s3[0];
		fb_rise = st.e_s2[1] && !st.e_s3[1];
		if (fb_rise)
			nx.ld_idle = '0;
		else if (st.ld_idle != LD_TMO_CYC)
			nx.ld_idle = st.ld_idle + 9'h1;
		else
			nx.syslock = 1'b0;
		if (ref_rise && fb_rise)
		begin
			nx.ld_run = 1'b0;
			nx.syslock = 1'b1;
		end
		else if (ref_rise)
		begin
			nx.ld_run = 1'b1;
			nx.ld_cnt = '0;
		end
		else if (st.ld_run)
		begin
			if (fb_rise)
			begin
				nx.ld_run = 1'b0;
				nx.syslock = st.ld_cnt < LD_THR_CYC;
			end
			else if (st.ld_cnt != LD_TMO_CYC)
				nx.ld_cnt = st.ld_cnt + 9'h1;
		end

		// ----------------------------------------
		// Stability timer
		// ----------------------------------------
		if (!st.syslock)
		begin
			nx.stab_cnt = '0;
			nx.stable = 1'b0;
		end
		else if (!st.stable)
		begin
			if (st.stab_cnt >= st.stab)
				nx.stable = 1'b1;
			else
				nx.stab_cnt = st.stab_cnt + 24'h1;
		end

		// ----------------------------------------
		// Tuning word history
		// ----------------------------------------
		if (st.lstate == LS_LOCK && tw_valid)
		begin
			acc_sum = st.acc + ACC_W'(tw_in);
			if (st.acc_n == (16'h1 << st.avglen) - 16'h1)
			begin
				nx.avg = TW_W'(acc_sum >> st.avglen);
				nx.hist_ok = 1'b1;
				nx.acc = '0;
				nx.acc_n = '0;
			end
			else
			begin
				nx.acc = acc_sum;
				nx.acc_n = st.acc_n + 16'h1;
			end
		end

		// ----------------------------------------
		// Loop control state machine
		// ----------------------------------------
		ref_ok = st.ref_s2 && st.stable;
		uhold = st.mode[MODE_UHOLD_BIT];
		case (st.lstate)
			LS_FREE, LS_HOLD:
				if (ref_ok && !uhold)
				begin
					nx.lstate = LS_LOCK;
					nx.cur_ref = st.id_s2;
					nx.profile_load = 1'b1;
				end
			LS_LOCK:
				if (!ref_ok || uhold)
					nx.lstate = st.hist_ok ? LS_HOLD : LS_FREE;
				else if (st.id_s2 != st.cur_ref)
				begin
					nx.lstate = LS_SWITCH;
					nx.sw_cnt = '0;
					nx.cur_ref = st.id_s2;
					nx.profile_load = 1'b1;
				end
			LS_SWITCH:
				if (!ref_ok || uhold)
					nx.lstate = st.hist_ok ? LS_HOLD : LS_FREE;
				else if (st.sw_cnt == SWITCH_CYC - 4'h1)
					nx.lstate = LS_LOCK;
				else
					nx.sw_cnt = st.sw_cnt + 4'h1;
			default:
				nx.lstate = LS_FREE;
		endcase

		case (nx.lstate)
			LS_LOCK:
				nx.lock = dpll_lock_in;
			LS_SWITCH:
				nx.lock = st.lock;
			default:
				nx.lock = 1'b0;
		endcase

		case (nx.lstate)
			LS_LOCK:
				nx.tune = tw_valid ? tw_in : st.tune;
			LS_FREE:
				nx.tune = free_run_tuning_word;
			default:
				nx.tune = nx.hist_ok ? nx.avg : free_run_tuning_word;
		endcase

		if (sys_rst)
		begin
			nx = '0;
			nx.fdiv = FDIV_RST;
			nx.cfg = CFG_RST;
			nx.mode = MODE_RST;
			nx.period = PERIOD_RST;
			nx.stab = STAB_RST;
			nx.avglen = AVGLEN_RST;
			nx.act_fdiv = FDIV_RST;
			nx.act_cfg = CFG_RST;
			nx.lstate = LS_FREE;
		end
	end

	always_ff @(posedge core_clk)
		st <= nx;

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign axi_rsp.awready = !st.aw_have && !st.bvalid;
	assign axi_rsp.wready  = !st.w_have && !st.bvalid;
	assign axi_rsp.bvalid  = st.bvalid;
	assign axi_rsp.bresp   = st.bresp;
	assign axi_rsp.arready = !st.rvalid;
	assign axi_rsp.rvalid  = st.rvalid;
	assign axi_rsp.rdata   = st.rdata;
	assign axi_rsp.rresp   = st.rresp;
	assign tune_word       = st.tune;
	assign dpll_locked     = st.lock;
	assign loop_state      = st.lstate;
	assign profile_load    = st.profile_load;
	assign sysclk_locked   = st.syslock;
	assign sysclk_stable   = st.stable;
	assign monitors_en     = st.stable;
	assign crystal_route   = st.act_cfg[CFG_ROUTE_BIT];
	assign prescale_sel    = st.act_cfg[CFG_PRE_LSB +: 2];
	assign doubler_en      = st.act_cfg[CFG_DBL_BIT];
	assign post_div_sel    = st.act_cfg[CFG_POST_LSB +: 2];
	assign fb_div          = st.act_fdiv;
	assign nominal_period  = st.period;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (sys_rst);

	sequence s_sw_enter;
		st.lstate == LS_LOCK ##1 st.lstate == LS_SWITCH;
	endsequence

	a_switch_lock: assert property (s_sw_enter |-> dpll_locked == $past(dpll_locked))
		else $error("Lock indication moved at switchover");
	a_switch_load: assert property (s_sw_enter |-> profile_load)
		else $error("No profile load on switchover");
	a_switch_exit: assert property (st.lstate == LS_SWITCH && st.sw_cnt == SWITCH_CYC - 4'h1
		&& ref_ok
		&& !uhold |=> st.lstate == LS_LOCK)
		else $error("Switchover did not recover");
	a_hold_unlock: assert property (st.lstate == LS_HOLD || st.lstate == LS_FREE
		|-> !dpll_locked)
		else $error("Locked shown in holdover or free run");
	a_uhold_stay: assert property (uhold && st.lstate == LS_HOLD |=> st.lstate == LS_HOLD)
		else $error("Left holdover under user hold");
	a_hold_tune: assert property (st.lstate == LS_HOLD && st.hist_ok |-> tune_word == st.avg)
		else $error("Holdover word is not the average");
	a_hold_recover: assert property (st.lstate == LS_HOLD && ref_ok && !uhold
		|=> st.lstate == LS_LOCK && profile_load)
		else $error("No recovery from holdover");
	a_stab_clear: assert property (!st.syslock |=> st.stab_cnt == 24'h0 && !sysclk_stable)
		else $error("Stability timer not cleared");
	a_stab_rise: assert property ($rose(sysclk_stable) |-> $past(st.stab_cnt) >= st.stab)
		else $error("Stable reported early");
	a_mon_gate: assert property (!st.stable && st.lstate == LS_FREE |=> st.lstate == LS_FREE)
		else $error("Loop acted before clock stable");
	a_div_update: assert property ($changed(fb_div) |-> $past(upd))
		else $error("Divider changed without update");
	a_div_range: assert property (fb_div >= FDIV_MIN)
		else $error("Feedback divide below minimum");

endmodule

/* File: lhc_pkg.sv */
// Constants, types and register map for the loop and system clock control
// Assumes one 200 MHz core clock and AXI4-Lite register access
package lhc_pkg;

	// ----------------------------------------
	// Register indexes (byte address = 4 * index)
	// ----------------------------------------
	localparam logic [13:0] IDX_UPDATE = 14'h0005;
	localparam logic [13:0] IDX_FDIV   = 14'h0100;
	localparam logic [13:0] IDX_CFG    = 14'h0101;
	localparam logic [13:0] IDX_PERIOD = 14'h0103;
	localparam logic [13:0] IDX_STAB   = 14'h0106;
	localparam logic [13:0] IDX_AVGLEN = 14'h0107;
	localparam logic [13:0] IDX_MODE   = 14'h0a01;
	localparam logic [13:0] IDX_STATUS = 14'h0d00;
	localparam logic [13:0] IDX_AVG    = 14'h0d01;

	// ----------------------------------------
	// Fields and reset values
	// ----------------------------------------
	localparam int          CFG_ROUTE_BIT  = 0;
	localparam int          CFG_POST_LSB   = 1;
	localparam int          CFG_PRE_LSB    = 3;
	localparam int          CFG_DBL_BIT    = 5;
	localparam int          MODE_UHOLD_BIT = 6;
	localparam logic [7:0]  UPDATE_GO      = 8'h01;
	localparam logic [7:0]  FDIV_MIN       = 8'h04;
	localparam logic [7:0]  FDIV_RST       = 8'h28;
	localparam logic [7:0]  CFG_RST        = 8'h00;
	localparam logic [7:0]  MODE_RST       = 8'h00;
	localparam logic [23:0] PERIOD_RST     = 24'h000000;
	localparam logic [23:0] STAB_RST       = 24'h000100;
	localparam logic [3:0]  AVGLEN_RST     = 4'h4;
	localparam logic [1:0]  RESP_OKAY      = 2'b00;
	localparam logic [1:0]  RESP_SLVERR    = 2'b10;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int         CLK_NS     = 5;
	localparam int         LD_THR_NS  = 20;
	localparam int         LD_TMO_NS  = 2000;
	localparam int         SWITCH_NS  = 50;
	localparam logic [8:0] LD_THR_CYC = 9'(LD_THR_NS / CLK_NS);
	localparam logic [8:0] LD_TMO_CYC = 9'(LD_TMO_NS / CLK_NS);
	localparam logic [3:0] SWITCH_CYC = 4'((SWITCH_NS + CLK_NS - 1) / CLK_NS);

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [1:0] {
		LS_FREE   = 2'b00,
		LS_LOCK   = 2'b01,
		LS_SWITCH = 2'b10,
		LS_HOLD   = 2'b11
	} lhc_loop_e;

	typedef struct packed {
		logic        awvalid;
		logic [15:0] awaddr;
		logic        wvalid;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        bready;
		logic        arvalid;
		logic [15:0] araddr;
		logic        rready;
	} lhc_axi_req_s;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} lhc_axi_rsp_s;

endpackage

/* File: lhc_far_model.sv */
// Far-side model: sysclk oscillator and multiplier edges, reference status, DPLL
// Assumes the bench clock; every output changes just after a rising edge
module lhc_far_model
(
	input  wire logic        core_clk,
	input  wire logic        osc_run,
	input  wire logic [2:0]  fb_lag,
	input  wire logic        ref_on,
	input  wire logic [1:0]  ref_sel,
	input  wire logic        lock_drop,
	input  wire logic [31:0] tw_base,
	output logic             ref_present,
	output logic [1:0]       ref_index,
	output logic             sysclk_ref_edge,
	output logic             sysclk_fb_edge,
	output logic             dpll_lock_in,
	output logic [31:0]      tw_in,
	output logic             tw_valid
);
	logic [7:0] osc_hist;
	logic [3:0] osc_cnt;
	logic       tw_phase;

	initial
	begin
		osc_hist = '0;
		osc_cnt = '0;
		tw_phase = 1'b0;
		{ref_present, ref_index, dpll_lock_in, tw_in, tw_valid} = '0;
	end

	// ----------------------------------------
	// Oscillator stands still when stopped
	// ----------------------------------------
	always @(posedge core_clk)
	begin
		osc_cnt <= osc_run ? osc_cnt + 4'h1 : 4'h0;
		osc_hist <= {osc_hist[6:0], osc_run & osc_cnt[3]};
		tw_phase <= ~tw_phase;
		tw_in <= tw_phase ? tw_base + 32'h2 : tw_base;
		tw_valid <= 1'b1;
		ref_present <= ref_on;
		ref_index <= ref_sel;
		// DPLL drops its own lock while the reference is gone or disturbed
		dpll_lock_in <= ref_on & ~lock_drop;
	end

	// Feedback lags reference by a chosen number of cycles
	assign sysclk_ref_edge = osc_hist[0];
	assign sysclk_fb_edge = osc_hist[fb_lag];
endmodule

/* File: tb_loop_holdover_and_sysclk_control.sv */
// Self-checking bench for the loop and system clock control block
// Assumes lhc_pkg, the design and the far-side model compiled first
module tb_loop_holdover_and_sysclk_control;
	timeunit 1ns;
	timeprecision 100ps;
	import lhc_pkg::*;

	localparam logic [31:0] FREE_W = 32'h40000000;
	localparam logic [31:0] TW_B   = 32'h12345670;
	localparam int          STAB   = 32;

	logic         core_clk  = 1'b0;
	logic         sys_rst   = 1'b1;
	lhc_axi_req_s axi_req   = '0;
	lhc_axi_rsp_s axi_rsp;
	logic         osc_run   = 1'b0;
	logic [2:0]   fb_lag    = 3'h1;
	logic         ref_on    = 1'b0;
	logic [1:0]   ref_sel   = 2'h0;
	logic         lock_drop = 1'b0;
	logic         ref_present, sysclk_ref_edge, sysclk_fb_edge, dpll_lock_in, tw_valid;
	logic [1:0]   ref_index, loop_state, prescale_sel, post_div_sel;
	logic [31:0]  tw_in, tune_word;
	logic         dpll_locked, profile_load, sysclk_locked, sysclk_stable, monitors_en;
	logic         crystal_route, doubler_en;
	logic [7:0]   fb_div;
	logic [23:0]  nominal_period;
	int           errors = 0;
	int           check_count = 0;
	int           loads = 0;
	int           n;
	int           k;

	lhc_loop_sysclk lhc_loop_sysclk_inst (.core_clk, .sys_rst, .axi_req, .axi_rsp,
		.ref_present, .ref_index, .sysclk_ref_edge, .sysclk_fb_edge, .dpll_lock_in,
		.tw_in, .tw_valid, .free_run_tuning_word(FREE_W), .tune_word, .dpll_locked,
		.loop_state, .profile_load, .sysclk_locked, .sysclk_stable, .monitors_en,
		.crystal_route, .prescale_sel, .doubler_en, .post_div_sel, .fb_div,
		.nominal_period);

	lhc_far_model lhc_far_model_inst (.core_clk, .osc_run, .fb_lag, .ref_on, .ref_sel,
		.lock_drop, .tw_base(TW_B), .ref_present, .ref_index, .sysclk_ref_edge,
		.sysclk_fb_edge, .dpll_lock_in, .tw_in, .tw_valid);

	always #2.5 core_clk = ~core_clk;

	always @(posedge core_clk)
		if (profile_load === 1'b1)
			loads <= loads + 1;

	// ----------------------------------------
	// Compare, bus and wait tasks
	// ----------------------------------------
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp)
		begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wrc(input logic [13:0] idx, input logic [31:0] d, input logic [1:0] er);
		logic [1:0] r;
		@(posedge core_clk);
		axi_req.awvalid <= 1'b1;
		axi_req.awaddr <= {idx, 2'b00};
		axi_req.wvalid <= 1'b1;
		axi_req.wdata <= d;
		axi_req.wstrb <= 4'hf;
		axi_req.bready <= 1'b1;
		forever
		begin
			@(posedge core_clk);
			if (axi_req.awvalid && axi_rsp.awready)
				axi_req.awvalid <= 1'b0;
			if (axi_req.wvalid && axi_rsp.wready)
				axi_req.wvalid <= 1'b0;
			if (axi_rsp.bvalid)
			begin
				r = axi_rsp.bresp;
				axi_req.bready <= 1'b0;
				break;
			end
		end
		chk("write resp", er, r);
	endtask

	task automatic rdc(input logic [13:0] idx, input logic [31:0] exp, input logic [1:0] er);
		logic [31:0] d;
		logic [1:0]  r;
		@(posedge core_clk);
		axi_req.arvalid <= 1'b1;
		axi_req.araddr <= {idx, 2'b00};
		axi_req.rready <= 1'b1;
		forever
		begin
			@(posedge core_clk);
			if (axi_req.arvalid && axi_rsp.arready)
				axi_req.arvalid <= 1'b0;
			if (axi_rsp.rvalid)
			begin
				d = axi_rsp.rdata;
				r = axi_rsp.rresp;
				axi_req.rready <= 1'b0;
				break;
			end
		end
		chk("read data", exp, d);
		chk("read resp", er, r);
	endtask

	function automatic logic probe(input int kind, input logic [1:0] st);
		case (kind)
			0: return sysclk_locked;
			1: return sysclk_stable;
			default: return loop_state === st;
		endcase
	endfunction

	// Bounded wait; n holds the cycles spent
	task automatic wt(input int kind, input logic [1:0] st, input logic lvl);
		n = 0;
		while (probe(kind, st) !== lvl && n < 3000)
		begin
			@(posedge core_clk);
			n++;
		end
		chk("wait reached", 1, n < 3000);
	endtask

	task automatic give_verdict;
		$display("checks %0d mismatches %0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	initial
	begin
		#200000;
		errors++;
		$display("CHECK FAILED watchdog expected done seen timeout");
		give_verdict();
	end

	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial
	begin
		repeat (8) @(posedge core_clk);
		sys_rst <= 1'b0;
		repeat (4) @(posedge core_clk);
		chk("loop state", LS_FREE, loop_state);
		chk("free word", FREE_W, tune_word);
		chk("stable", 0, sysclk_stable);
		chk("monitors", 0, monitors_en);
		chk("fb div", FDIV_RST, fb_div);
		rdc(IDX_FDIV, FDIV_RST, RESP_OKAY);
		rdc(IDX_STAB, STAB_RST, RESP_OKAY);
		rdc(IDX_AVGLEN, AVGLEN_RST, RESP_OKAY);
		rdc(14'h0200, 0, RESP_SLVERR);
		wrc(14'h0200, 32'h5a, RESP_SLVERR);
		$display("test reset done");

		for (k = 0; k < 4; k++)
		begin
			wrc(IDX_FDIV, {24'h0, 2'(k), 6'h3f}, RESP_OKAY);
			wrc(IDX_CFG, {26'h0, k == 0, 2'(k), 2'(k), k[0]}, RESP_OKAY);
			chk("fb held", k == 0 ? FDIV_RST : {2'(k - 1), 6'h3f}, fb_div);
			wrc(IDX_UPDATE, UPDATE_GO, RESP_OKAY);
			@(posedge core_clk);
			chk("fb div", {2'(k), 6'h3f}, fb_div);
			chk("prescale", k, prescale_sel);
			chk("post div", k, post_div_sel);
			chk("route", k % 2, crystal_route);
			chk("doubler", k == 0, doubler_en);
		end
		wrc(IDX_FDIV, 32'h2, RESP_OKAY);
		wrc(IDX_UPDATE, UPDATE_GO, RESP_OKAY);
		@(posedge core_clk);
		chk("fb clamp", FDIV_MIN, fb_div);
		wrc(IDX_PERIOD, 32'h00abcdef, RESP_OKAY);
		@(posedge core_clk);
		chk("period", 24'habcdef, nominal_period);
		rdc(IDX_PERIOD, 32'h00abcdef, RESP_OKAY);
		$display("test dividers done");

		wrc(IDX_STAB, STAB, RESP_OKAY);
		osc_run <= 1'b1;
		wt(0, 0, 1);
		repeat (10) @(posedge core_clk);
		chk("stable early", 0, sysclk_stable);
		fb_lag <= 3'h6;
		wt(0, 0, 0);
		chk("stable on loss", 0, sysclk_stable);
		fb_lag <= 3'h1;
		wt(0, 0, 1);
		wt(1, 0, 1);
		chk("stable delay", 1, n >= STAB - 1 && n <= STAB + 3);
		chk("monitors", 1, monitors_en);
		$display("test stability done");

		ref_sel <= 2'h1;
		ref_on <= 1'b1;
		wt(2, LS_LOCK, 1);
		repeat (150) @(posedge core_clk);
		chk("profile loads", 1, loads);
		rdc(IDX_STATUS, 32'h7d, RESP_OKAY);
		rdc(IDX_AVG, TW_B + 1, RESP_OKAY);
		ref_sel <= 2'h2;
		wt(2, LS_SWITCH, 1);
		lock_drop <= 1'b1;
		repeat (5) @(posedge core_clk);
		chk("lock frozen", 1, dpll_locked);
		lock_drop <= 1'b0;
		wt(2, LS_LOCK, 1);
		chk("switch length", 1, n <= SWITCH_CYC + 2);
		chk("profile loads", 2, loads);
		$display("test lock and switch done");

		ref_on <= 1'b0;
		wt(2, LS_HOLD, 1);
		repeat (2) @(posedge core_clk);
		chk("lock in hold", 0, dpll_locked);
		chk("hold word", TW_B + 1, tune_word);
		wrc(IDX_MODE, 32'h40, RESP_OKAY);
		ref_on <= 1'b1;
		repeat (50) @(posedge core_clk);
		chk("user hold", LS_HOLD, loop_state);
		chk("lock in hold", 0, dpll_locked);
		wrc(IDX_MODE, 0, RESP_OKAY);
		wt(2, LS_LOCK, 1);
		wrc(IDX_MODE, 32'h40, RESP_OKAY);
		wt(2, LS_HOLD, 1);
		$display("test holdover done");
		give_verdict();
	end
endmodule
